// ===== shared/uart_mode_defs.vh
// Register map, field positions, codes and reset values of the serial port.
`ifndef UART_MODE_DEFS_VH
`define UART_MODE_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MODE        8'h00
`define OFS_TXDATA      8'h04
`define OFS_RXDATA      8'h08
`define OFS_STATUS      8'h0C
`define OFS_DIVISOR     8'h10

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MB_STOP         0
`define MB_FMT_LO       1
`define MB_FMT_HI       2
`define MB_HISPEED      3
`define MB_RECEIVE_POLARITY_INVERT        4
`define MB_AUTO_RATE_MEASURE        5
`define MB_LOOP         6
`define MB_WAKE         7
`define MB_PIN_LO       8
`define MB_PIN_HI       9
`define MB_RTSMODE      11
`define MB_INFRARED_CODEC_ENABLE         12
`define MODE_WMASK      32'h00001BFF
`define MODE_RESET      32'h00000000

// ----------------------------------------------------------------
// Frame format and pin usage codes
// ----------------------------------------------------------------
`define FMT_8N          2'h0
`define FMT_8E          2'h1
`define FMT_8O          2'h2
`define FMT_9N          2'h3
`define PINS_TXRX       2'h0
`define PINS_RTS        2'h1
`define PINS_FLOW       2'h2
`define PINS_BCLK       2'h3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SB_RXVALID      0
`define SB_PERR         1
`define SB_FERR         2
`define SB_OERR         3
`define SB_TXBUSY       4
`define SB_WAKE         5

// ----------------------------------------------------------------
// Oversampling, infrared pulse and rate measurement constants
// ----------------------------------------------------------------
`define OS16_LAST       4'hF
`define OS4_LAST        4'h3
`define OS16_HALF       4'h7
`define OS4_HALF        4'h1
`define IR16_TICKS      4'h3
`define IR4_TICKS       4'h1
`define SYNC_LAST_FALL  3'h3
`define SYNC_SHIFT16    5'h07
`define SYNC_SHIFT4     5'h05
`define DIV_RESET       16'h001A

`endif

// ===== src/rate_divider.v
// Divider that turns the system clock into the oversampling tick.
`timescale 1ns/10ps
module rate_divider #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Rate setting and tick
  input  wire [WIDTH-1:0] divisor,
  output reg              tick
);

  reg [WIDTH-1:0] count_reg;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // The compare is >= so that a smaller divisor written mid-count
  // takes effect at once instead of waiting for a full wrap.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= {WIDTH{1'b0}};
      tick      <= 1'b0;
    end else if (count_reg >= divisor) begin
      count_reg <= {WIDTH{1'b0}};
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick      <= 1'b0;
    end
  end

endmodule

// ===== src/uart_mode_core.v
// Asynchronous serial port with mode register, behind an AHB-Lite slave.
`timescale 1ns/10ps
`include "uart_mode_defs.vh"
module uart_mode_core #(
  parameter DIV_WIDTH = 16,
  parameter CNT_WIDTH = 24
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  // Serial pins
  input  wire        serial_receive_pin,
  output reg         serial_transmit_pin,
  input  wire        clear_to_send_pin_n,
  output reg         request_to_send_pin_n,
  output reg         baud_clock_output_pin,
  // Pin claims towards the general port
  output wire        transmit_claim,
  output wire        clear_to_send_claim,
  output wire        request_to_send_claim,
  output wire        baud_clock_claim,
  // Power management
  input  wire        sleep_active,
  output reg         wake_request
);

  localparam T_IDLE  = 3'h0;
  localparam T_START = 3'h1;
  localparam T_DATA  = 3'h2;
  localparam T_PAR   = 3'h3;
  localparam T_STOP  = 3'h4;

  function [3:0] os_last;
    input hs;
    begin
      os_last = hs ? `OS4_LAST : `OS16_LAST;
    end
  endfunction

  function par_bit;
    input [1:0] fmt;
    input [7:0] d;
    begin
      par_bit = (fmt == `FMT_8O) ? ~(^d) : (^d);
    end
  endfunction

  reg  [31:0]          mode_reg;
  reg  [DIV_WIDTH-1:0] div_reg;
  reg                  wr_pend_reg;
  reg  [7:0]           wr_addr_reg;
  reg                  rd_wait_reg;
  reg  [7:0]           rd_addr_reg;
  reg  [2:0]           tx_state_reg;
  reg  [3:0]           tx_os_reg;
  reg  [3:0]           tx_idx_reg;
  reg  [8:0]           tx_shift_reg;
  reg  [8:0]           tx_buf_reg;
  reg                  tx_pend_reg;
  reg                  tx_bit_reg;
  reg  [2:0]           rx_state_reg;
  reg  [3:0]           rx_os_reg;
  reg  [3:0]           rx_idx_reg;
  reg  [8:0]           rx_shift_reg;
  reg  [8:0]           rx_data_reg;
  reg                  rx_valid_reg;
  reg                  perr_reg;
  reg                  ferr_reg;
  reg                  oerr_reg;
  reg                  wakef_reg;
  reg                  rx_prev_reg;
  reg  [3:0]           ir_hold_reg;
  reg  [3:0]           bclk_ph_reg;
  reg                  ab_run_reg;
  reg  [2:0]           ab_fall_reg;
  reg  [CNT_WIDTH-1:0] ab_cnt_reg;
  wire                 tick;

  wire [1:0] fmt     = mode_reg[`MB_FMT_HI:`MB_FMT_LO];
  wire [1:0] pins    = mode_reg[`MB_PIN_HI:`MB_PIN_LO];
  wire       hs      = mode_reg[`MB_HISPEED];
  wire       infrared_codec_enable    = mode_reg[`MB_INFRARED_CODEC_ENABLE];
  wire       loop_en = mode_reg[`MB_LOOP];
  wire       armed   = mode_reg[`MB_AUTO_RATE_MEASURE];
  wire [3:0] last    = os_last(hs);
  wire [3:0] half    = hs ? `OS4_HALF : `OS16_HALF;
  wire [3:0] nbits_m1 = (fmt == `FMT_9N) ? 4'h8 : 4'h7;
  wire       has_par = (fmt == `FMT_8E) || (fmt == `FMT_8O);
  wire       addr_ok = hsel & htrans[1] & hready;
  wire       wr_mode = wr_pend_reg && (wr_addr_reg == `OFS_MODE);
  wire       wr_tx   = wr_pend_reg && (wr_addr_reg == `OFS_TXDATA);
  wire       wr_stat = wr_pend_reg && (wr_addr_reg == `OFS_STATUS);
  wire       wr_div  = wr_pend_reg && (wr_addr_reg == `OFS_DIVISOR);
  wire       rd_rx   = rd_wait_reg && (rd_addr_reg == `OFS_RXDATA);
  wire       tx_busy = (tx_state_reg != T_IDLE) | tx_pend_reg;

  rate_divider #(
    .WIDTH   (DIV_WIDTH)
  ) u_rate (
    .hclk    (hclk),
    .hresetn (hresetn),
    .divisor (div_reg),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so that a read following a write sees
  // the written value; writes complete with no wait.
  assign hreadyout = ~rd_wait_reg;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_wait_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_wait_reg <= addr_ok & ~hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr;
        rd_addr_reg <= haddr;
      end
      if (rd_wait_reg) begin
        case (rd_addr_reg)
          `OFS_MODE:    hrdata <= mode_reg;
          `OFS_RXDATA:  hrdata <= {23'h000000, rx_data_reg};
          `OFS_STATUS:  hrdata <= {26'h0000000, wakef_reg, tx_busy,
                                   oerr_reg, ferr_reg, perr_reg,
                                   rx_valid_reg};
          `OFS_DIVISOR: hrdata <= {{(32-DIV_WIDTH){1'b0}}, div_reg};
          default:      hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit and receive line conditioning
  // ----------------------------------------------------------------
  wire tx_enc  = infrared_codec_enable ? (~tx_bit_reg &&
                 (tx_os_reg < (hs ? `IR4_TICKS : `IR16_TICKS)))
                      : tx_bit_reg;
  // Loopback takes the encoder output directly, so a mode change cannot
  // replay the previous line level into the receiver as a false start.
  wire rx_raw  = loop_en ? tx_enc
                         : serial_receive_pin ^ mode_reg[`MB_RECEIVE_POLARITY_INVERT];
  // In infrared mode a high pulse marks a zero bit; the hold counter
  // stretches it over one bit time.
  wire rx_line = infrared_codec_enable ? ~(rx_raw | (ir_hold_reg != 4'h0))
                      : rx_raw;
  wire rx_fall = rx_prev_reg & ~rx_line;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_transmit_pin     <= 1'b1;
      rx_prev_reg             <= 1'b1;
      ir_hold_reg             <= 4'h0;
    end else begin
      // The pin stays idle while the transmitter is looped back.
      serial_transmit_pin <= loop_en ? ~infrared_codec_enable : tx_enc;
      rx_prev_reg <= rx_line;
      if (tick) begin
        if (infrared_codec_enable && rx_raw)
          ir_hold_reg <= last;
        else if (ir_hold_reg != 4'h0)
          ir_hold_reg <= ir_hold_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode and divisor registers, rate measurement
  // ----------------------------------------------------------------
  // The sync character gives five falling edges two bits apart, so
  // the divisor is the span over eight bits times the oversampling, less one.
  wire [CNT_WIDTH-1:0] cnt_one = {{(CNT_WIDTH-1){1'b0}}, 1'b1};
  wire [CNT_WIDTH-1:0] ab_div = (ab_cnt_reg >>
                 (hs ? `SYNC_SHIFT4 : `SYNC_SHIFT16)) - cnt_one;
  wire ab_done = armed && ab_run_reg && rx_fall &&
                 (ab_fall_reg == `SYNC_LAST_FALL);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg    <= `MODE_RESET;
      div_reg     <= `DIV_RESET;
      ab_run_reg  <= 1'b0;
      ab_fall_reg <= 3'h0;
      ab_cnt_reg  <= {CNT_WIDTH{1'b0}};
    end else begin
      if (ab_done) begin
        div_reg              <= ab_div[DIV_WIDTH-1:0];
        mode_reg[`MB_AUTO_RATE_MEASURE]  <= 1'b0;
      end else if (wr_div)
        div_reg <= hwdata[DIV_WIDTH-1:0];
      if (wr_mode)
        mode_reg <= hwdata & `MODE_WMASK;
      if (!armed || ab_done) begin
        ab_run_reg <= 1'b0;
      end else if (rx_fall) begin
        ab_run_reg  <= 1'b1;
        ab_fall_reg <= ab_run_reg ? ab_fall_reg + 3'h1 : 3'h0;
        // The edge cycle is counted, so the total is the exact span.
        if (!ab_run_reg)
          ab_cnt_reg <= cnt_one;
        else
          ab_cnt_reg <= ab_cnt_reg + cnt_one;
      end else if (ab_run_reg)
        ab_cnt_reg <= ab_cnt_reg + cnt_one;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  wire cts_ok = (pins != `PINS_FLOW) | ~clear_to_send_pin_n;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= T_IDLE;
      tx_os_reg    <= 4'h0;
      tx_idx_reg   <= 4'h0;
      tx_shift_reg <= 9'h000;
      tx_buf_reg   <= 9'h000;
      tx_pend_reg  <= 1'b0;
      tx_bit_reg   <= 1'b1;
    end else begin
      if (wr_tx && !tx_busy) begin
        tx_buf_reg  <= hwdata[8:0];
        tx_pend_reg <= 1'b1;
      end
      if (tick) begin
        if (tx_state_reg == T_IDLE) begin
          tx_os_reg <= 4'h0;
          if (tx_pend_reg && cts_ok) begin
            tx_pend_reg  <= 1'b0;
            tx_shift_reg <= tx_buf_reg;
            tx_bit_reg   <= 1'b0;
            tx_state_reg <= T_START;
          end
        end else if (tx_os_reg != last) begin
          tx_os_reg <= tx_os_reg + 4'h1;
        end else begin
          tx_os_reg <= 4'h0;
          case (tx_state_reg)
            T_START: begin
              tx_bit_reg   <= tx_shift_reg[0];
              tx_idx_reg   <= 4'h0;
              tx_state_reg <= T_DATA;
            end
            T_DATA: begin
              if (tx_idx_reg == nbits_m1) begin
                tx_idx_reg <= 4'h0;
                if (has_par) begin
                  tx_bit_reg   <= par_bit(fmt, tx_buf_reg[7:0]);
                  tx_state_reg <= T_PAR;
                end else begin
                  tx_bit_reg   <= 1'b1;
                  tx_state_reg <= T_STOP;
                end
              end else begin
                tx_idx_reg   <= tx_idx_reg + 4'h1;
                tx_bit_reg   <= tx_shift_reg[tx_idx_reg + 4'h1];
              end
            end
            T_PAR: begin
              tx_bit_reg   <= 1'b1;
              tx_idx_reg   <= 4'h0;
              tx_state_reg <= T_STOP;
            end
            T_STOP: begin
              if (tx_idx_reg == {3'h0, mode_reg[`MB_STOP]})
                tx_state_reg <= T_IDLE;
              else
                tx_idx_reg <= tx_idx_reg + 4'h1;
            end
            default: tx_state_reg <= T_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // The receiver is held idle while a rate measurement is armed, so the
  // sync character up to its fifth falling edge is not delivered as data;
  // its last data bit, still low, is then taken as a start bit.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= T_IDLE;
      rx_os_reg    <= 4'h0;
      rx_idx_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_data_reg  <= 9'h000;
      rx_valid_reg <= 1'b0;
      perr_reg     <= 1'b0;
      ferr_reg     <= 1'b0;
      oerr_reg     <= 1'b0;
    end else begin
      if (rd_rx)
        rx_valid_reg <= 1'b0;
      if (wr_stat) begin
        if (hwdata[`SB_PERR]) perr_reg <= 1'b0;
        if (hwdata[`SB_FERR]) ferr_reg <= 1'b0;
        if (hwdata[`SB_OERR]) oerr_reg <= 1'b0;
      end
      if (armed) begin
        rx_state_reg <= T_IDLE;
      end else if (tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
        case (rx_state_reg)
          T_IDLE: begin
            rx_os_reg <= 4'h0;
            if (!rx_line)
              rx_state_reg <= T_START;
          end
          T_START: begin
            if (rx_os_reg == half) begin
              rx_os_reg    <= 4'h0;
              rx_idx_reg   <= 4'h0;
              rx_state_reg <= rx_line ? T_IDLE : T_DATA;
            end
          end
          T_DATA: begin
            if (rx_os_reg == last) begin
              rx_os_reg    <= 4'h0;
              rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
              rx_idx_reg   <= rx_idx_reg + 4'h1;
              if (rx_idx_reg == nbits_m1)
                rx_state_reg <= has_par ? T_PAR : T_STOP;
            end
          end
          T_PAR: begin
            if (rx_os_reg == last) begin
              rx_os_reg <= 4'h0;
              if (rx_line != par_bit(fmt, rx_shift_reg[8:1]))
                perr_reg <= 1'b1;
              rx_state_reg <= T_STOP;
            end
          end
          T_STOP: begin
            if (rx_os_reg == last) begin
              rx_state_reg <= T_IDLE;
              rx_data_reg  <= (fmt == `FMT_9N) ? rx_shift_reg
                              : {1'b0, rx_shift_reg[8:1]};
              rx_valid_reg <= 1'b1;
              if (!rx_line)
                ferr_reg <= 1'b1;
              if (rx_valid_reg && !rd_rx)
                oerr_reg <= 1'b1;
            end
          end
          default: rx_state_reg <= T_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin control, baud clock and wake-up
  // ----------------------------------------------------------------
  assign transmit_claim        = 1'b1;
  assign request_to_send_claim = (pins == `PINS_RTS) ||
                                 (pins == `PINS_FLOW);
  assign clear_to_send_claim   = (pins == `PINS_FLOW);
  assign baud_clock_claim      = (pins == `PINS_BCLK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request_to_send_pin_n <= 1'b1;
      baud_clock_output_pin <= 1'b0;
      bclk_ph_reg           <= 4'h0;
      wake_request          <= 1'b0;
      wakef_reg             <= 1'b0;
    end else begin
      // Simplex drives the line while sending; flow control asks for
      // data while the receive holding register is free.
      request_to_send_pin_n <= mode_reg[`MB_RTSMODE] ? ~tx_busy
                                                     : rx_valid_reg;
      if (tick)
        bclk_ph_reg <= (bclk_ph_reg >= last) ? 4'h0
                                             : bclk_ph_reg + 4'h1;
      baud_clock_output_pin <= (bclk_ph_reg <= half);
      wake_request <= sleep_active && mode_reg[`MB_WAKE] && rx_fall;
      if (sleep_active && mode_reg[`MB_WAKE] && rx_fall)
        wakef_reg <= 1'b1;
      else if (wr_stat && hwdata[`SB_WAKE])
        wakef_reg <= 1'b0;
    end
  end

endmodule

// ===== tb/uart_mode_core_assertions.sv
// Concurrent checks on the bus, pin-claim and wake ports of the port.
`timescale 1ns/10ps
`include "uart_mode_defs.vh"
module uart_mode_core_assertions (
  // Clock and reset
  input logic        hclk,
  input logic        hresetn,
  // Bus
  input logic        hsel,
  input logic [7:0]  haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  // Claims and wake
  input logic        transmit_claim,
  input logic        clear_to_send_claim,
  input logic        request_to_send_claim,
  input logic        baud_clock_claim,
  input logic        wake_request
);
  logic       take;
  logic       mode_wr_reg;
  logic [2:0] mirror_reg;

  assign take = hsel && htrans[1] && hready;

  // Mirrors the pin-usage code and the wake enable of the mode register.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_wr_reg <= 1'b0;
      mirror_reg  <= 3'h0;
    end else begin
      mode_wr_reg <= take && hwrite && haddr == `OFS_MODE;
      if (mode_wr_reg) begin
        mirror_reg <= hwdata[9:7];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  tx_claim_a: assert property (transmit_claim)
    else $error("transmit pins not claimed");
  cts_claim_a: assert property (
    clear_to_send_claim == (mirror_reg[2:1] == 2'h2))
    else $error("clear-to-send claim wrong");
  rts_claim_a: assert property (
    request_to_send_claim ==
      (mirror_reg[2:1] == 2'h1 || mirror_reg[2:1] == 2'h2))
    else $error("request-to-send claim wrong");
  bclk_claim_a: assert property (
    baud_clock_claim == (mirror_reg[2:1] == 2'h3))
    else $error("baud clock claim wrong");
  wake_pulse_a: assert property (
    $rose(wake_request) |=> !wake_request)
    else $error("wake request longer than one cycle");
  wake_enable_a: assert property (
    wake_request |-> $past(mirror_reg[0]))
    else $error("wake request while wake disabled");
endmodule

bind uart_mode_core uart_mode_core_assertions chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .transmit_claim(transmit_claim),
  .clear_to_send_claim(clear_to_send_claim),
  .request_to_send_claim(request_to_send_claim),
  .baud_clock_claim(baud_clock_claim), .wake_request(wake_request)
);

// ===== tb/remote_link.sv
// Remote transceiver model that drives frames onto the receive line.
`timescale 1ns/10ps
module remote_link (
  // Clock
  input  logic hclk,
  // Receive line of the port
  output logic line
);
  logic bit_reg = 1'b1;
  logic inv     = 1'b0;

  // A low-idle line is the mirror image of a high-idle one.
  assign line = bit_reg ^ inv;

  // Sends n bits LSB first, each for clks cycles, then rests at idle.
  task automatic send(input logic [11:0] frame, input int n, input int clks);
    for (int i = 0; i < n; i++) begin
      bit_reg <= frame[i];
      repeat (clks) @(posedge hclk);
    end
    bit_reg <= 1'b1;
  endtask
endmodule

// ===== tb/uart_mode_configuration_tb.sv
// Self-checking bench for the serial port with mode register.
`timescale 1ns/10ps
`include "uart_mode_defs.vh"
module uart_mode_configuration_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        rx_line, tx_line, cts_n, rts_n, sleep, wake;
  logic        tx_cl, cts_cl, rts_cl, bclk_cl, bclk;
  int          errors, samples_checked, n;
  logic [7:0]  row_a [5] = '{8'h00, 8'h00, 8'h10, 8'h14, 8'h10};
  logic [31:0] row_d [5] = '{32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF,
                             32'hFFFFFFFF, 32'h1};
  logic [31:0] row_e [5] = '{32'h1BFF, 32'h0, 32'hFFFF, 32'h0, 32'h1};
  logic [31:0] pmode [3] = '{32'h2, 32'h4, 32'h6};
  logic [11:0] pfrm  [3] = '{12'h402, 12'h402, 12'h786};
  logic [31:0] pdata [3] = '{32'h01, 32'h01, 32'h1C3};
  logic        pperr [3] = '{1'b1, 1'b0, 1'b0};

  uart_mode_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .serial_receive_pin(rx_line),
    .serial_transmit_pin(tx_line), .clear_to_send_pin_n(cts_n),
    .request_to_send_pin_n(rts_n), .baud_clock_output_pin(bclk),
    .transmit_claim(tx_cl), .clear_to_send_claim(cts_cl),
    .request_to_send_claim(rts_cl), .baud_clock_claim(bclk_cl),
    .sleep_active(sleep), .wake_request(wake)
  );
  remote_link peer (.hclk(hclk), .line(rx_line));

  always #10 hclk = ~hclk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_rx;
    rd = 0;
    for (int i = 0; i < 200 && rd[0] !== 1'b1; i++) bus(`OFS_STATUS, 0, 0);
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    #1500000;
    errors++;
    summarize;
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, cts_n, sleep} = 6'h0;
    {haddr, htrans, hwdata} = 42'h0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(`OFS_MODE, 0, 0);
    chk(rd, `MODE_RESET);
    bus(`OFS_DIVISOR, 0, 0);
    chk(rd, {16'h0, `DIV_RESET});
    for (int r = 0; r < 5; r++) begin
      bus(row_a[r], 1, row_d[r]);
      bus(row_a[r], 0, 0);
      chk(rd, row_e[r]);
    end
    for (int c = 0; c < 4; c++) begin
      bus(`OFS_MODE, 1, c << 8);
      @(negedge hclk);
      chk({tx_cl, cts_cl, rts_cl, bclk_cl},
          {1'b1, c == 2, c == 1 || c == 2, c == 3});
      if (c == 2) chk(rts_n, 0);
    end
    for (int i = 0; i < 5; i++) begin
      bus(`OFS_MODE, 1, (i / 4) << 12 | 32'h40 | (i % 4) << 1 | i % 2);
      bus(`OFS_TXDATA, 1, 32'h1A5);
      wait_rx;
      chk(rd & 32'h6, 0);
      bus(`OFS_RXDATA, 0, 0);
      chk(rd, i == 3 ? 32'h1A5 : 32'hA5);
      // Let the stop bits drain before the format changes.
      repeat (64) @(posedge hclk);
    end
    for (int h = 0; h < 2; h++) begin
      bus(`OFS_MODE, 1, 32'h900 | h << 3);
      bus(`OFS_TXDATA, 1, 0);
      n = 0;
      while (tx_line !== 1'b0 && n < 100) begin @(negedge hclk); n++; end
      chk(rts_n, 0);
      n = 0;
      while (tx_line === 1'b0 && n < 400) begin @(negedge hclk); n++; end
      chk(n, h ? 72 : 288);
      repeat (400) @(negedge hclk);
      chk(rts_n, 1);
    end
    for (int r = 0; r < 3; r++) begin
      bus(`OFS_MODE, 1, pmode[r]);
      peer.send(pfrm[r], 11, 32);
      wait_rx;
      chk(rd[1], pperr[r]);
      bus(`OFS_RXDATA, 0, 0);
      chk(rd, pdata[r]);
      bus(`OFS_STATUS, 1, 32'h2E);
    end
    // The baud clock is high for half of each bit time.
    while (bclk !== 1'b0) @(negedge hclk);
    while (bclk !== 1'b1) @(negedge hclk);
    n = 0;
    while (bclk === 1'b1 && n < 100) begin
      @(negedge hclk);
      n++;
    end
    chk(n, 16);
    bus(`OFS_DIVISOR, 1, 32'h1A);
    bus(`OFS_MODE, 1, 32'h20);
    peer.send(12'h2AA, 10, 32);
    bus(`OFS_MODE, 0, 0);
    chk(rd, 0);
    bus(`OFS_DIVISOR, 0, 0);
    chk(rd, 1);
    sleep <= 1'b1;
    bus(`OFS_MODE, 1, 32'h80);
    n = 0;
    fork
      peer.send(12'h7FE, 11, 32);
      while (wake !== 1'b1 && n < 400) begin @(negedge hclk); n++; end
    join
    chk(n < 400, 1);
    bus(`OFS_STATUS, 0, 0);
    chk(rd[5], 1);
    sleep <= 1'b0;
    // The line resting low is first taken for a broken character.
    peer.inv <= 1'b1;
    repeat (500) @(posedge hclk);
    bus(`OFS_MODE, 1, 32'h10);
    repeat (400) @(posedge hclk);
    bus(`OFS_RXDATA, 0, 0);
    bus(`OFS_STATUS, 1, 32'h2F);
    peer.send(12'h278, 10, 32);
    wait_rx;
    chk(rd & 32'h6, 0);
    bus(`OFS_RXDATA, 0, 0);
    chk(rd, 32'h3C);
    summarize;
  end
endmodule
